// ### verilog/power_ctl_pkg.sv
package power_ctl_pkg;
  // Bus geometry
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // Register byte offsets
  localparam logic [3:0] OFF_MOD_HALT = 4'h0;
  localparam logic [3:0] OFF_PWR_CTRL = 4'h4;
  localparam logic [3:0] OFF_INT_EN = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hc;

  // Clock-halt register, a 0 in bit 7, 2 or 1 holds its module in standby
  localparam int HALT_W = 8;
  localparam int HALT_SERIAL2_BIT = 7;
  localparam int HALT_RSVD_BIT = 3;
  localparam int HALT_TIMER2_BIT = 2;
  localparam int HALT_FLASH_BIT = 1;
  localparam logic [HALT_W-1:0] MOD_HALT_RST = 8'hff;

  // Power control fields
  localparam int PCTL_W = 4;
  localparam int PCTL_DT_ON_BIT = 0;
  localparam int PCTL_MED_ON_BIT = 1;
  localparam int PCTL_LOW_ON_BIT = 2;
  localparam int PCTL_SW_STANDBY_BIT = 3;
  localparam logic [PCTL_W-1:0] PCTL_RST = 4'h0;

  // Interrupt enable fields
  localparam int IRQ_W = 8;
  localparam int IEN_W = 9;
  localparam int IEN_DT_BIT = 8;
  localparam logic [IEN_W-1:0] IEN_RST = 9'h000;

  // Status fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_SPEED_LSB = 2;

  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_WATCH = 2'h3
  } power_mode_t;

  typedef enum logic [1:0] {
    SPEED_HIGH = 2'h0,
    SPEED_MEDIUM = 2'h1,
    SPEED_LOW = 2'h2
  } speed_t;
endpackage : power_ctl_pkg

// ### verilog/module_standby_clock_halt.sv
// Behaviour
// RULE1: clearing halt bit 7 stops the second serial channel clock, module in standby.
// RULE2: clearing halt bit 2 halts the second timer and puts it in standby.
// RULE3: clearing halt bit 1 puts the flash memory module into standby.
// RULE4: halt bit 3 is reserved, resets to 1, read/write, affects nothing.
// RULE5: an interrupt changes power mode only when that request is enabled.
// RULE6: sleep with direct-transition interrupt disabled enters sleep or watch instead.
// RULE7: setting a halt bit back to 1 restores that module's clock.
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module module_standby_clock_halt (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [power_ctl_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [power_ctl_pkg::DATA_W-1:0] hrdata,
  output logic [1:0] hresp,
  // CPU and interrupt controller, same clock
  input wire logic sleep_exec,
  input wire logic [power_ctl_pkg::IRQ_W-1:0] irq_req,
  // Module standby controls, high holds the module with its clock stopped
  output logic serial2_standby,
  output logic timer2_standby,
  output logic flash_standby,
  // Power mode outputs
  output logic cpu_clock_run,
  output power_ctl_pkg::power_mode_t power_mode,
  output power_ctl_pkg::speed_t speed_sel,
  output logic direct_transition
);
  import power_ctl_pkg::*;

  logic dp_valid_r, dp_valid_nxt;
  logic dp_write_r, dp_write_nxt;
  logic [ADDR_W-1:0] dp_addr_r, dp_addr_nxt;
  logic hreadyout_r, hreadyout_nxt;
  logic [DATA_W-1:0] hrdata_r, hrdata_nxt;
  logic [1:0] hresp_r;
  logic accept;
  logic wr_en;
  logic rd_done;
  logic [DATA_W-1:0] rd_data;

  logic [HALT_W-1:0] module_clock_halt_a_r, module_clock_halt_a_nxt;
  logic [PCTL_W-1:0] pctl_r, pctl_nxt;
  logic [IEN_W-1:0] interrupt_enable_two_r, interrupt_enable_two_nxt;
  logic serial2_standby_r, serial2_standby_nxt;
  logic timer2_standby_r, timer2_standby_nxt;
  logic flash_standby_r, flash_standby_nxt;

  power_mode_t mode_r, mode_nxt;
  speed_t speed_r, speed_nxt;
  speed_t speed_target;
  logic dt_pulse_r, dt_pulse_nxt;
  logic cpu_run_r, cpu_run_nxt;
  logic wake_req;
  logic direct_transition_on;
  logic low_speed_on;
  logic medium_speed_on;
  logic software_standby_select;
  logic dt_irq_enable;

  // Bus decode; hsize is ignored since only whole-word transfers occur
  assign accept = hsel && htrans[1] && hready;
  assign wr_en = dp_valid_r && dp_write_r && hreadyout_r;
  assign rd_done = dp_valid_r && !dp_write_r && !hreadyout_r;

  // Read mux; unmapped offsets read as zero with an OKAY answer
  always_comb begin
    rd_data = '0;
    case (dp_addr_r)
      OFF_MOD_HALT: rd_data[HALT_W-1:0] = module_clock_halt_a_r;
      OFF_PWR_CTRL: rd_data[PCTL_W-1:0] = pctl_r;
      OFF_INT_EN: rd_data[IEN_W-1:0] = interrupt_enable_two_r;
      OFF_STATUS: begin
        rd_data[STAT_MODE_LSB +: 2] = mode_r;
        rd_data[STAT_SPEED_LSB +: 2] = speed_r;
      end
      default: rd_data = '0;
    endcase
  end

  // Bus slave next state; reads take one wait state so hrdata comes from a flop
  always_comb begin
    dp_valid_nxt = dp_valid_r;
    dp_write_nxt = dp_write_r;
    dp_addr_nxt = dp_addr_r;
    hreadyout_nxt = 1'b1;
    hrdata_nxt = hrdata_r;
    if (hready) begin
      dp_valid_nxt = accept;
      dp_write_nxt = hwrite;
      dp_addr_nxt = haddr[ADDR_W-1:0];
      if (accept && !hwrite) begin
        hreadyout_nxt = 1'b0;
      end
    end
    if (rd_done) begin
      hrdata_nxt = rd_data;
    end
  end

  // Bus slave registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= '0;
      hreadyout_r <= 1'b1;
      hrdata_r <= '0;
      hresp_r <= HRESP_OKAY;
    end else begin
      dp_valid_r <= dp_valid_nxt;
      dp_write_r <= dp_write_nxt;
      dp_addr_r <= dp_addr_nxt;
      hreadyout_r <= hreadyout_nxt;
      hrdata_r <= hrdata_nxt;
      hresp_r <= HRESP_OKAY;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = hresp_r;

  // Software registers; standby flags follow the halt bits in the same edge
  always_comb begin
    module_clock_halt_a_nxt = module_clock_halt_a_r;
    pctl_nxt = pctl_r;
    interrupt_enable_two_nxt = interrupt_enable_two_r;
    if (wr_en) begin
      case (dp_addr_r)
        OFF_MOD_HALT: module_clock_halt_a_nxt = hwdata[HALT_W-1:0]; // RULE4
        OFF_PWR_CTRL: pctl_nxt = hwdata[PCTL_W-1:0];
        OFF_INT_EN: interrupt_enable_two_nxt = hwdata[IEN_W-1:0];
        default: pctl_nxt = pctl_r;
      endcase
    end
    // Standby only gates clocks, it never resets, so state survives a halt
    serial2_standby_nxt = !module_clock_halt_a_nxt[HALT_SERIAL2_BIT]; // RULE1 RULE7
    timer2_standby_nxt = !module_clock_halt_a_nxt[HALT_TIMER2_BIT]; // RULE2 RULE7
    flash_standby_nxt = !module_clock_halt_a_nxt[HALT_FLASH_BIT]; // RULE3 RULE7
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_clock_halt_a_r <= MOD_HALT_RST;
      pctl_r <= PCTL_RST;
      interrupt_enable_two_r <= IEN_RST;
      serial2_standby_r <= 1'b0;
      timer2_standby_r <= 1'b0;
      flash_standby_r <= 1'b0;
    end else begin
      module_clock_halt_a_r <= module_clock_halt_a_nxt;
      pctl_r <= pctl_nxt;
      interrupt_enable_two_r <= interrupt_enable_two_nxt;
      serial2_standby_r <= serial2_standby_nxt;
      timer2_standby_r <= timer2_standby_nxt;
      flash_standby_r <= flash_standby_nxt;
    end
  end

  assign serial2_standby = serial2_standby_r;
  assign timer2_standby = timer2_standby_r;
  assign flash_standby = flash_standby_r;

  // Power control fields
  assign direct_transition_on = pctl_r[PCTL_DT_ON_BIT];
  assign medium_speed_on = pctl_r[PCTL_MED_ON_BIT];
  assign low_speed_on = pctl_r[PCTL_LOW_ON_BIT];
  assign software_standby_select = pctl_r[PCTL_SW_STANDBY_BIT];
  assign dt_irq_enable = interrupt_enable_two_r[IEN_DT_BIT];
  // A raised but masked request must not wake the core
  assign wake_req = |(irq_req & interrupt_enable_two_r[IRQ_W-1:0]); // RULE5

  // Target speed of a direct transition; low speed takes priority over medium
  always_comb begin
    if (low_speed_on) begin
      speed_target = SPEED_LOW;
    end else if (medium_speed_on) begin
      speed_target = SPEED_MEDIUM;
    end else begin
      speed_target = SPEED_HIGH;
    end
  end

  // Power mode machine; sleep requests outside active mode are ignored
  always_comb begin
    mode_nxt = mode_r;
    speed_nxt = speed_r;
    dt_pulse_nxt = 1'b0;
    case (mode_r)
      MODE_ACTIVE: begin
        if (sleep_exec) begin
          if (direct_transition_on && dt_irq_enable) begin
            speed_nxt = speed_target;
            dt_pulse_nxt = 1'b1;
          end else if (software_standby_select) begin
            mode_nxt = MODE_WATCH; // RULE6
          end else begin
            mode_nxt = MODE_SLEEP; // RULE6
          end
        end
      end
      MODE_SLEEP, MODE_WATCH: begin
        if (wake_req) begin
          mode_nxt = MODE_ACTIVE; // RULE5
        end
      end
      default: mode_nxt = MODE_ACTIVE;
    endcase
    cpu_run_nxt = (mode_nxt == MODE_ACTIVE);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= MODE_ACTIVE;
      speed_r <= SPEED_HIGH;
      dt_pulse_r <= 1'b0;
      cpu_run_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      speed_r <= speed_nxt;
      dt_pulse_r <= dt_pulse_nxt;
      cpu_run_r <= cpu_run_nxt;
    end
  end

  assign power_mode = mode_r;
  assign speed_sel = speed_r;
  assign direct_transition = dt_pulse_r;
  assign cpu_clock_run = cpu_run_r;

  // Bus timing: a read stalls exactly one cycle, a write never stalls
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    accept && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not exactly one wait state");

  a_write_no_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    accept && hwrite |=> hreadyout)
    else $error("write data phase inserted a wait state");

  // Read-back of the halt register shows the stored bits, reserved one included
  a_halt_readback: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
    accept && !hwrite && haddr[ADDR_W-1:0] == OFF_MOD_HALT
    |=> ##1 hrdata[HALT_W-1:0] == $past(module_clock_halt_a_r))
    else $error("halt register read-back differs from stored bits");

  // Checks tying standby outputs to the written halt bits
  a_serial_halt_set: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
    wr_en && dp_addr_r == OFF_MOD_HALT && !hwdata[HALT_SERIAL2_BIT]
    |=> serial2_standby && !module_clock_halt_a_r[HALT_SERIAL2_BIT])
    else $error("serial channel not in standby after halt bit cleared");

  a_timer_halt_set: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
    wr_en && dp_addr_r == OFF_MOD_HALT && !hwdata[HALT_TIMER2_BIT]
    |=> timer2_standby)
    else $error("timer not in standby after halt bit cleared");

  a_flash_halt_set: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
    $fell(module_clock_halt_a_r[HALT_FLASH_BIT]) |-> flash_standby)
    else $error("flash not in standby when its halt bit falls");

  a_rsvd_no_effect: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
    $changed(module_clock_halt_a_r[HALT_RSVD_BIT])
    && $stable(module_clock_halt_a_r[HALT_SERIAL2_BIT])
    && $stable(module_clock_halt_a_r[HALT_TIMER2_BIT])
    && $stable(module_clock_halt_a_r[HALT_FLASH_BIT])
    |-> $stable(serial2_standby) && $stable(timer2_standby) && $stable(flash_standby))
    else $error("reserved halt bit changed a standby output");

  a_masked_no_wake: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
    mode_r != MODE_ACTIVE && !(|(irq_req & interrupt_enable_two_r[IRQ_W-1:0]))
    |=> power_mode == $past(mode_r) && !cpu_clock_run)
    else $error("power mode left without an enabled interrupt");

  a_enabled_wake: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
    mode_r != MODE_ACTIVE && wake_req |=> power_mode == MODE_ACTIVE ##0 cpu_clock_run)
    else $error("enabled interrupt did not wake the core");

  a_no_direct_trans: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
    mode_r == MODE_ACTIVE && sleep_exec && !dt_irq_enable
    |=> !direct_transition && power_mode != MODE_ACTIVE && $stable(speed_sel))
    else $error("direct transition taken while its interrupt is disabled");

  a_direct_trans: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
    mode_r == MODE_ACTIVE && sleep_exec && dt_irq_enable && direct_transition_on
    |=> direct_transition && power_mode == MODE_ACTIVE ##1 !direct_transition)
    else $error("enabled direct transition not one active-mode pulse");

  a_clock_restore: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
    serial2_standby && wr_en && dp_addr_r == OFF_MOD_HALT && hwdata[HALT_SERIAL2_BIT]
    |=> !serial2_standby && module_clock_halt_a_r[HALT_SERIAL2_BIT]
    ##1 (!serial2_standby || $past(wr_en && dp_addr_r == OFF_MOD_HALT)))
    else $error("serial channel clock not restored after halt bit set");

  a_timer_restore: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
    timer2_standby && wr_en && dp_addr_r == OFF_MOD_HALT && hwdata[HALT_TIMER2_BIT]
    |=> !timer2_standby)
    else $error("timer clock not restored after halt bit set");

  a_flash_restore: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
    flash_standby && wr_en && dp_addr_r == OFF_MOD_HALT && hwdata[HALT_FLASH_BIT]
    |=> !flash_standby)
    else $error("flash clock not restored after halt bit set");

endmodule : module_standby_clock_halt

// ### testbench/test_module_standby_clock_halt.sv
`timescale 1ns/1ps
// One comparison: counted, and any difference is reported at once
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module test_module_standby_clock_halt;
  import power_ctl_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, sleep_exec;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [IRQ_W-1:0] irq_req;
  logic serial2_standby, timer2_standby, flash_standby, cpu_clock_run, direct_transition;
  power_mode_t power_mode;
  speed_t speed_sel;
  int mismatches, total_checks;
  wire hready = hreadyout; // Single slave, so its ready is the bus ready
  logic [7:0] halt_v [4] = '{8'h7f, 8'hfb, 8'hfd, 8'hf7};
  logic [2:0] sb_v [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
  logic [31:0] pctl_v [2] = '{32'h0000_0005, 32'h0000_0003};
  speed_t spd_v [2] = '{SPEED_LOW, SPEED_MEDIUM};

  module_standby_clock_halt dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sleep_exec(sleep_exec),
    .irq_req(irq_req), .serial2_standby(serial2_standby), .timer2_standby(timer2_standby),
    .flash_standby(flash_standby), .cpu_clock_run(cpu_clock_run), .power_mode(power_mode),
    .speed_sel(speed_sel), .direct_transition(direct_transition)
  );

  // 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task print_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Edge-sampled wait for ready; a hung slave ends the run instead of stalling it
  task wait_ready;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        print_verdict();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  task bus_wr(input logic [3:0] a, input logic [31:0] d);
    haddr <= {28'h000_0000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    hsel <= 1'b1;
    wait_ready();
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    wait_ready();
  endtask : bus_wr

  // Read data is taken at the edge that ends the data phase
  task bus_rd(input logic [3:0] a, output logic [31:0] d);
    haddr <= {28'h000_0000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    hsel <= 1'b1;
    wait_ready();
    htrans <= HTRANS_IDLE;
    wait_ready();
    d = hrdata;
    `CHK(hresp, HRESP_OKAY)
  endtask : bus_rd

  // Sleep instruction pulse; outputs are sampled one cycle after it is taken
  task do_sleep;
    @(posedge hclk);
    sleep_exec <= 1'b1;
    @(posedge hclk);
    sleep_exec <= 1'b0;
    @(posedge hclk);
  endtask : do_sleep

  task wait_mode(input power_mode_t m);
    int n;
    n = 0;
    @(posedge hclk);
    while (power_mode !== m && n < 10) begin
      n++;
      @(posedge hclk);
    end
    // A mode that never arrives ends the run through the report
    if (power_mode !== m) begin
      mismatches++;
      print_verdict();
    end
    `CHK(power_mode, m)
  endtask : wait_mode

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    sleep_exec = 1'b0;
    irq_req = 8'h00;
    mismatches = 0;
    total_checks = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    // Out of reset every module runs and the halt bits read as ones
    bus_rd(OFF_MOD_HALT, rd);
    `CHK(rd, 32'h0000_00ff)
    `CHK({serial2_standby, timer2_standby, flash_standby}, 3'b000)
    `CHK(cpu_clock_run, 1'b1)
    // Clear each bit alone, then set it back; the reserved bit gates nothing
    for (int i = 0; i < 4; i++) begin
      bus_wr(OFF_MOD_HALT, {24'h00_0000, halt_v[i]});
      @(posedge hclk);
      `CHK({serial2_standby, timer2_standby, flash_standby}, sb_v[i])
      bus_rd(OFF_MOD_HALT, rd);
      `CHK(rd, {24'h00_0000, halt_v[i]})
      bus_wr(OFF_MOD_HALT, 32'h0000_00ff);
      @(posedge hclk);
      `CHK({serial2_standby, timer2_standby, flash_standby}, 3'b000)
    end
    // A masked request must leave the device asleep until it is enabled
    bus_wr(OFF_PWR_CTRL, 32'h0000_0000);
    bus_wr(OFF_INT_EN, 32'h0000_0000);
    do_sleep();
    `CHK(power_mode, MODE_SLEEP)
    `CHK(cpu_clock_run, 1'b0)
    irq_req <= 8'h01;
    repeat (5) @(posedge hclk);
    `CHK(power_mode, MODE_SLEEP)
    bus_wr(OFF_INT_EN, 32'h0000_0001);
    wait_mode(MODE_ACTIVE);
    irq_req <= 8'h00;
    // Direct transition asked for but its interrupt disabled: watch instead
    bus_wr(OFF_PWR_CTRL, 32'h0000_0009);
    do_sleep();
    `CHK(power_mode, MODE_WATCH)
    `CHK(direct_transition, 1'b0)
    bus_wr(OFF_INT_EN, 32'h0000_0002);
    irq_req <= 8'h02;
    wait_mode(MODE_ACTIVE);
    irq_req <= 8'h00;
    // With its interrupt enabled the transition happens and the core keeps running
    bus_wr(OFF_INT_EN, 32'h0000_0100);
    for (int i = 0; i < 2; i++) begin
      bus_wr(OFF_PWR_CTRL, pctl_v[i]);
      do_sleep();
      `CHK(direct_transition, 1'b1)
      `CHK(speed_sel, spd_v[i])
      `CHK(power_mode, MODE_ACTIVE)
    end
    // Status is read-only: a write leaves the reported speed and mode alone
    bus_wr(OFF_STATUS, 32'hffff_ffff);
    bus_rd(OFF_STATUS, rd);
    `CHK(rd, 32'h0000_0004)
    print_verdict();
  end
endmodule : test_module_standby_clock_halt
